// ---- rtl/spcs_defines.vh ----
// constants for the page context stack block
// assumes inclusion by bare name from rtl files
`ifndef SPCS_DEFINES_VH
`define SPCS_DEFINES_VH

`define SPCS_ADDR_MID    8'h85
`define SPCS_ADDR_BOT    8'ha7
`define SPCS_ADDR_CTRL   8'h84
`define SPCS_CTRL_PAGE   8'h0f
`define SPCS_RST_ENTRY   8'h00
`define SPCS_RST_AUTOEN  1'b1
`define SPCS_AUTOEN_BIT  0

`endif

// ---- rtl/spcs_entry.v ----
// one byte entry of the page stack with shift and direct write
// assumes load strobes from logic on the same clock; priority done outside
module spcs_entry #(
  parameter W = 8
) (
  input  wire         clock,
  input  wire         arst_n,
  input  wire         load,
  input  wire [W-1:0] load_val,
  output reg  [W-1:0] q_ff
);

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      q_ff <= {W{1'b0}};
    else if (load)
      q_ff <= load_val;
  end

endmodule

// ---- rtl/spcs_page_stack.v ----
// three-entry page context stack with direct register access
// assumes core gives one-cycle int_entry and return_from_interrupt_instruction pulses on this clock
`include "spcs_defines.vh"

module spcs_page_stack (
  input  wire       clock,
  input  wire       arst_n,
  input  wire       int_entry,
  input  wire [7:0] int_page,
  input  wire       return_from_interrupt_instruction,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_ff,
  output reg  [7:0] active_page_select_ff,
  output reg        auto_paging_enable_ff,
  output reg  [7:0] page_stack_middle_entry_ff,
  output reg  [7:0] page_stack_bottom_entry_ff
);

  // operation that moves the stack bytes this cycle
  localparam [1:0] OP_NONE = 2'b00;
  localparam [1:0] OP_PUSH = 2'b01;
  localparam [1:0] OP_POP  = 2'b10;
  localparam [1:0] OP_REG  = 2'b11;

  wire [7:0] mid_q;
  wire [7:0] bot_q;
  wire       push;
  wire       pop;
  wire       ctl_page;
  wire       hit_mid;
  wire       hit_bot;
  wire       hit_ctl;
  wire       wr_mid;
  wire       wr_bot;
  wire       wr_ctl;
  reg  [1:0] op;
  reg  [7:0] nxt_top;
  reg  [7:0] nxt_mid;
  reg  [7:0] nxt_bot;
  reg  [7:0] nxt_rdata;
  reg        nxt_auto_en;
  reg        mid_ld;
  reg        bot_ld;

  // address match, gated by a page condition where one applies
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    input       page_ok;
    begin
      addr_hit = (addr == target) && page_ok;
    end
  endfunction

  assign push     = int_entry & auto_paging_enable_ff;
  // push wins, so a same-cycle return is lost
  assign pop      = return_from_interrupt_instruction & auto_paging_enable_ff & ~push;
  assign ctl_page = (active_page_select_ff == `SPCS_CTRL_PAGE);

  // entry decode is page-independent, control decode needs page 0x0f
  // 0xa7 is the bottom entry on every page, so the active page
  // has no software path through this bus
  assign hit_mid = addr_hit(reg_addr, `SPCS_ADDR_MID, 1'b1);
  assign hit_bot = addr_hit(reg_addr, `SPCS_ADDR_BOT, 1'b1);
  assign hit_ctl = addr_hit(reg_addr, `SPCS_ADDR_CTRL, ctl_page);
  assign wr_mid  = reg_wr & hit_mid;
  assign wr_bot  = reg_wr & hit_bot;
  assign wr_ctl  = reg_wr & hit_ctl;

  // one operation per cycle, stack motion before writes
  always @*
  begin
    op = OP_NONE;
    if (push)
      op = OP_PUSH;
    else if (pop)
      op = OP_POP;
    else if (wr_mid | wr_bot)
      op = OP_REG;
  end

  // top entry: only interrupt entry and return move it
  always @*
  begin
    nxt_top = active_page_select_ff;
    case (op)
      OP_PUSH:
        nxt_top = int_page;
      OP_POP:
        nxt_top = mid_q;
      default:
        nxt_top = active_page_select_ff;
    endcase
  end

  // middle entry
  always @*
  begin
    nxt_mid = mid_q;
    mid_ld  = 1'b0;
    case (op)
      OP_PUSH:
      begin
        nxt_mid = active_page_select_ff;
        mid_ld  = 1'b1;
      end
      OP_POP:
      begin
        nxt_mid = bot_q;
        mid_ld  = 1'b1;
      end
      OP_REG:
      begin
        if (wr_mid)
        begin
          nxt_mid = reg_wdata;
          mid_ld  = 1'b1;
        end
      end
      default:
      begin
        nxt_mid = mid_q;
        mid_ld  = 1'b0;
      end
    endcase
  end

  // bottom entry
  always @*
  begin
    nxt_bot = bot_q;
    bot_ld  = 1'b0;
    case (op)
      OP_PUSH:
      begin
        // middle moves down, the old bottom byte is lost
        nxt_bot = mid_q;
        bot_ld  = 1'b1;
      end
      OP_REG:
      begin
        if (wr_bot)
        begin
          nxt_bot = reg_wdata;
          bot_ld  = 1'b1;
        end
      end
      default:
      begin
        // a pop keeps the bottom byte, so two pops repeat it
        nxt_bot = bot_q;
        bot_ld  = 1'b0;
      end
    endcase
  end

  always @*
  begin
    nxt_rdata = 8'h00;
    if (hit_mid)
      nxt_rdata = mid_q;
    else if (hit_bot)
      nxt_rdata = bot_q;
    else if (hit_ctl)
      nxt_rdata = {7'h00, auto_paging_enable_ff};
  end

  // enable written only on the control page
  always @*
  begin
    nxt_auto_en = auto_paging_enable_ff;
    if (wr_ctl)
      nxt_auto_en = reg_wdata[`SPCS_AUTOEN_BIT];
  end

  spcs_entry #(.W(8)) u_mid (
    .clock    (clock),
    .arst_n   (arst_n),
    .load     (mid_ld),
    .load_val (nxt_mid),
    .q_ff     (mid_q)
  );

  spcs_entry #(.W(8)) u_bot (
    .clock    (clock),
    .arst_n   (arst_n),
    .load     (bot_ld),
    .load_val (nxt_bot),
    .q_ff     (bot_q)
  );

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      active_page_select_ff      <= `SPCS_RST_ENTRY;
      page_stack_middle_entry_ff <= `SPCS_RST_ENTRY;
      page_stack_bottom_entry_ff <= `SPCS_RST_ENTRY;
    end
    else
    begin
      active_page_select_ff      <= nxt_top;
      page_stack_middle_entry_ff <= nxt_mid;
      page_stack_bottom_entry_ff <= nxt_bot;
    end
  end

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      auto_paging_enable_ff <= `SPCS_RST_AUTOEN;
    else
      auto_paging_enable_ff <= nxt_auto_en;
  end

  // read data holds between reads
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata_ff <= 8'h00;
    else if (reg_rd)
      reg_rdata_ff <= nxt_rdata;
  end

endmodule

// ---- test/spcs_core_model.sv ----
// core side: turns bench requests into entry and return pulses
// assumes requests change just after the rising edge
module spcs_core (
  input  wire       clock,
  input  wire       req_push,
  input  wire       req_pop,
  input  wire [7:0] page,
  output logic      int_entry = 0,
  output logic      return_from_interrupt_instruction = 0,
  output logic[7:0] int_page = 0
);
  always @(posedge clock)
  begin
    int_entry <= req_push;
    return_from_interrupt_instruction <= req_pop;
    // page only valid with the pulse, so scramble it otherwise
    int_page <= req_push ? page : ~int_page;
  end
endmodule

// ---- test/spcs_page_stack_assertions.sv ----
// checker on the page stack ports
// assumes one clock domain, bound to every stack instance
module spcs_chk (
  input wire       clock, arst_n, int_entry, return_from_interrupt_instruction, reg_wr, reg_rd,
  input wire [7:0] int_page, reg_addr, reg_wdata, reg_rdata_ff,
  input wire [7:0] active_page_select_ff, page_stack_middle_entry_ff,
  input wire [7:0] page_stack_bottom_entry_ff,
  input wire       auto_paging_enable_ff
);
  wire [7:0] p = active_page_select_ff;
  wire [7:0] m = page_stack_middle_entry_ff;
  wire [7:0] b = page_stack_bottom_entry_ff;
  wire       e = auto_paging_enable_ff;
  wire       ev = (int_entry | return_from_interrupt_instruction) & e;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  AST_POP: assert property (return_from_interrupt_instruction && !int_entry && e |=>
    p == $past(m) && m == $past(b) && $stable(b)) else $error("bad pop");
  AST_PUSH: assert property (int_entry && e |=> p == $past(int_page)
    && m == $past(p) && b == $past(m)) else $error("bad push");
  AST_HOLD: assert property (!int_entry && !return_from_interrupt_instruction && !reg_wr |=>
    $stable(p) && $stable(m) && $stable(b)) else $error("shift");
  AST_OFF: assert property (!e && !reg_wr |=> $stable(p)
    && $stable(m) && $stable(b)) else $error("moved while off");
  AST_MWR: assert property (reg_wr && reg_addr == 8'h85 && !ev |=>
    m == $past(reg_wdata) && $stable(b) && $stable(p))
    else $error("mid write");
  AST_BWR: assert property (reg_wr && reg_addr == 8'ha7 && !ev |=>
    b == $past(reg_wdata) && $stable(m) && $stable(p))
    else $error("bot write");
  AST_MRD: assert property (reg_rd && reg_addr == 8'h85 |=>
    reg_rdata_ff == $past(m)) else $error("mid read");
  AST_BRD: assert property (reg_rd && reg_addr == 8'ha7 |=>
    reg_rdata_ff == $past(b)) else $error("bot read");
endmodule
bind spcs_page_stack spcs_chk i_chk (.*);

// ---- test/test_spcs_page_stack.sv ----
// random bench for the page stack with a reference model
// assumes the core model and the checker are compiled first
module test_spcs_page_stack;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, arst_n = 0, pu = 0, po = 0, wr = 0, rd = 0;
  logic [7:0] a = 0, d = 0, pg = 0, mp, mm, mb, mr, tb[4];
  logic me, ce;
  wire ie, rt, e;
  wire [7:0] ip, rdat, p, m, b;
  int err_count = 0, check_count = 0, cyc = 0;
  bit [31:0] s = 80362, r;
  function bit [31:0] xs();
    s ^= s << 13; s ^= s >> 17; s ^= s << 5;
    return s;
  endfunction
  task chk(input string n, input [7:0] x, input [7:0] g);
    check_count++;
    if (x !== g)
    begin
      $display("Error %s expected %h seen %h", n, x, g);
      err_count++;
    end
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial forever #10 clock = ~clock;
  spcs_core i_core (.clock(clock), .req_push(pu), .req_pop(po),
    .page(pg), .int_entry(ie), .return_from_interrupt_instruction(rt), .int_page(ip));
  spcs_page_stack i_dut (.clock(clock), .arst_n(arst_n), .int_entry(ie),
    .int_page(ip), .return_from_interrupt_instruction(rt), .reg_addr(a), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(d), .reg_rdata_ff(rdat), .active_page_select_ff(p),
    .auto_paging_enable_ff(e), .page_stack_middle_entry_ff(m),
    .page_stack_bottom_entry_ff(b));
  always @(posedge clock or negedge arst_n)
    if (!arst_n)
      {mp, mm, mb, mr, me} = {32'h0, 1'b1};
    else
    begin
      if (rd)
        mr = a == 8'h85 ? mm : a == 8'ha7 ? mb :
          (a == 8'h84 && mp == 8'h0f) ? {7'h0, me} : 8'h00;
      // control write sees the page before any stack motion
      ce = wr && a == 8'h84 && mp == 8'h0f;
      // push wins, and stack motion drops a same-cycle entry write
      if (me && ie) {mb, mm, mp} = {mm, mp, ip};
      else if (me && rt) {mp, mm} = {mm, mb};
      else if (wr && a == 8'h85) mm = d;
      else if (wr && a == 8'ha7) mb = d;
      if (ce) me = d[0];
    end
  always @(negedge clock)
    if (arst_n)
    begin
      chk("top", mp, p);
      chk("middle", mm, m);
      chk("bottom", mb, b);
      chk("enable", {7'h0, me}, {7'h0, e});
      chk("read", mr, rdat);
    end
  always @(posedge clock)
    if (++cyc > 4000)
    begin
      err_count++;
      final_report();
    end
  task run(input int n);
    repeat (n)
    begin
      @(posedge clock);
      r = xs();
      pu <= r[0] & r[1];
      po <= r[2] & r[3];
      wr <= r[4];
      rd <= r[5] & ~r[4];
      a <= tb[r[7:6]];
      d <= r[17] ? 8'h0f : r[15:8];
      pg <= r[16] ? 8'h0f : r[31:24];
    end
  endtask
  initial
  begin
    tb = '{8'h85, 8'ha7, 8'h84, 8'h12};
    repeat (4) @(posedge clock);
    arst_n <= 1;
    run(2000);
    $display("random stack test done");
    // quiet the requests, then reset with the stack full of data
    @(posedge clock);
    {pu, po, wr, rd} <= 4'h0;
    repeat (2) @(posedge clock);
    arst_n <= 0;
    repeat (4) @(posedge clock);
    arst_n <= 1;
    run(1000);
    $display("mid-run reset test done");
    final_report();
  end
endmodule
